// >>> core/fprs_consts.svh
// Constants for the flash program, resume and status controller
`ifndef FPRS_CONSTS_SVH
`define FPRS_CONSTS_SVH
// Own register offsets on APB
`define FPRS_OFS_CTRL 8'h00
`define FPRS_OFS_ADDR 8'h04
`define FPRS_OFS_WDATA 8'h08
`define FPRS_OFS_STATUS 8'h0C
`define FPRS_OFS_RDATA 8'h10
`define FPRS_OFS_PAIRS 8'h14
// Control register field positions
`define FPRS_CTRL_OP_LSB 0
`define FPRS_CTRL_OP_MSB 2
`define FPRS_CTRL_LOOP 3
`define FPRS_OP_LAST 3'h5
// Flash command cycles
`define FPRS_UNLOCK1_ADDR 19'h00555
`define FPRS_UNLOCK1_DATA 8'hAA
`define FPRS_UNLOCK2_ADDR 19'h002AA
`define FPRS_UNLOCK2_DATA 8'h55
`define FPRS_PROGRAM_CODE 8'hA0
`define FPRS_RESET_CODE 8'hF0
`define FPRS_SUSPEND_CODE 8'hB0
`define FPRS_RESUME_CODE 8'h30
// Status bit positions on the data bus
`define FPRS_BIT_POLL 7
`define FPRS_BIT_TOG1 6
`define FPRS_BIT_TLE 5
// Timing
`define FPRS_CLK_MHZ 200
`define FPRS_WE_LOW_NS 45
`define FPRS_WE_HIGH_NS 20
`define FPRS_RD_ACC_NS 90
`define FPRS_RD_FLOAT_NS 20
`define FPRS_RESUME_GAP_US 400
`define FPRS_PAIR_LIMIT 1024
`define FPRS_NS2CYC(ns) (((ns) * `FPRS_CLK_MHZ + 999) / 1000)
`define FPRS_GAP_CYC (`FPRS_RESUME_GAP_US * `FPRS_CLK_MHZ)
`endif

// >>> core/fprs_pkg.sv
// Types shared by the controller modules
package fprs_pkg;
   typedef enum logic [2:0] {
      OP_NONE, OP_PROGRAM, OP_RESUME, OP_SUSPEND, OP_RESET, OP_READ
   } fprs_op_e;
   typedef enum logic [3:0] {
      S_IDLE, S_UNLOCK1, S_UNLOCK2, S_CMD, S_DATA, S_POLL1, S_POLL2,
      S_EVAL, S_READ, S_HOLD, S_SINGLE, S_RESET
   } fprs_state_e;
   typedef enum logic [1:0] {P_IDLE, P_SETUP, P_ACTIVE, P_RECOVER} fprs_phase_e;
endpackage

// >>> core/fprs_pin_cycle.sv
// One write or read cycle on the flash pins
`timescale 1ns/1ps
`include "fprs_consts.svh"
module fprs_pin_cycle
   import fprs_pkg::*;
#(
   parameter int AW = 19
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic wr,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [AW-1:0] a,
   output logic [7:0] dq_o,
   output logic dq_oe,
   input wire logic [7:0] dq_i
);
   localparam logic [7:0] WE_LOW = 8'(`FPRS_NS2CYC(`FPRS_WE_LOW_NS));
   localparam logic [7:0] WE_HIGH = 8'(`FPRS_NS2CYC(`FPRS_WE_HIGH_NS));
   localparam logic [7:0] RD_ACC = 8'(`FPRS_NS2CYC(`FPRS_RD_ACC_NS));
   localparam logic [7:0] RD_FLT = 8'(`FPRS_NS2CYC(`FPRS_RD_FLOAT_NS));

   fprs_phase_e phase_q;
   logic [7:0] cnt_q;
   logic wr_q;

   // Active and recovery lengths for the current direction
   wire [7:0] act_len = wr_q ? WE_LOW : RD_ACC;
   wire [7:0] rec_len = wr_q ? WE_HIGH : RD_FLT;
   wire cnt_end = cnt_q == 8'h01;

   // Strobe sequencer: address and data stay put until recovery ends
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (!rst_n) begin
         phase_q <= P_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         rdata <= 8'h00;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         a <= '0;
         dq_o <= 8'h00;
         dq_oe <= 1'b0;
      end else begin
         unique case (phase_q)
            P_IDLE: if (start) begin
               wr_q <= wr;
               a <= addr;
               dq_o <= wdata;
               dq_oe <= wr;
               ce_n <= 1'b0;
               phase_q <= P_SETUP;
            end
            P_SETUP: begin
               we_n <= ~wr_q; // Falling strobe latches the address
               oe_n <= wr_q;
               cnt_q <= act_len;
               phase_q <= P_ACTIVE;
            end
            P_ACTIVE: if (cnt_end) begin
               we_n <= 1'b1; // Rising strobe latches data and starts it
               oe_n <= 1'b1;
               if (!wr_q) rdata <= dq_i;
               cnt_q <= rec_len;
               phase_q <= P_RECOVER;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
            P_RECOVER: begin
               ce_n <= 1'b1;
               if (cnt_end) begin
                  dq_oe <= 1'b0;
                  done <= 1'b1;
                  phase_q <= P_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
         endcase
      end
   end
endmodule

// >>> core/fprs_status_eval.sv
// Compares two consecutive status reads of the flash
`timescale 1ns/1ps
`include "fprs_consts.svh"
module fprs_status_eval
   import fprs_pkg::*;
(
   input wire logic [7:0] first,
   input wire logic [7:0] second,
   input wire logic [7:0] expect_data,
   output logic toggling,
   output logic limit_hit,
   output logic bits_match
);
   // Toggle bit one changed between the two reads
   assign toggling = first[`FPRS_BIT_TOG1] ^ second[`FPRS_BIT_TOG1];
   assign limit_hit = second[`FPRS_BIT_TLE];
   // Bits 7 and 6 equal to the written byte mean the program took
   assign bits_match = second[`FPRS_BIT_POLL:`FPRS_BIT_TOG1]
      == expect_data[`FPRS_BIT_POLL:`FPRS_BIT_TOG1];
endmodule

// >>> core/fprs_ctrl.sv
// Host-side controller that programs, resumes and polls a parallel flash
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fprs_consts.svh"
module fprs_ctrl
   import fprs_pkg::*;
#(
   parameter int AW = 19,
   parameter int GAP_CYC = `FPRS_GAP_CYC,
   parameter int PAIR_LIMIT = `FPRS_PAIR_LIMIT
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic FL_CE_N,
   output logic FL_WE_N,
   output logic FL_OE_N,
   output logic [AW-1:0] FL_ADDR,
   output logic [7:0] FL_DQ_O,
   output logic FL_DQ_OE,
   input wire logic [7:0] FL_DQ_I
);
   // Elaboration checks on parameters
   generate
      if (AW < 11 || AW > 31) begin : g_bad_aw
         $error("AW must lie in 11..31");
      end
      if (GAP_CYC < 1 || GAP_CYC > 131071) begin : g_bad_gap
         $error("GAP_CYC must lie in 1..131071");
      end
      if (PAIR_LIMIT < 1 || PAIR_LIMIT > 65534) begin : g_bad_pairs
         $error("PAIR_LIMIT must lie in 1..65534");
      end
   endgenerate

   // States that issue a flash pin cycle
   function automatic logic is_cyc(input fprs_state_e s);
      return !(s inside {S_IDLE, S_EVAL, S_HOLD});
   endfunction

   // States that issue a write cycle
   function automatic logic is_wr(input fprs_state_e s);
      return s inside {S_UNLOCK1, S_UNLOCK2, S_CMD, S_DATA, S_SINGLE, S_RESET};
   endfunction

   fprs_state_e state_q;
   fprs_state_e state_d;
   fprs_op_e op_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [AW-1:0] addr_q;
   logic [7:0] wdata_q;
   logic loop_q;
   logic done_q;
   logic fail_q;
   logic nochange_q;
   logic recheck_q;
   logic [7:0] rdata_q;
   logic [7:0] first_q;
   logic [7:0] second_q;
   logic [15:0] pairs_q;
   logic [16:0] gap_q;
   logic start_q;
   logic cyc_done;
   logic [7:0] cyc_rdata;
   logic toggling;
   logic limit_hit;
   logic bits_match;

   // APB handshake: one wait cycle, completion on the second access edge
   wire apb_acc = PSEL & PENABLE;
   wire apb_fin = apb_acc & pready_q;
   wire apb_wr = apb_fin & PWRITE;
   wire sel_ctrl = PADDR == `FPRS_OFS_CTRL;
   wire sel_addr = PADDR == `FPRS_OFS_ADDR;
   wire sel_wdata = PADDR == `FPRS_OFS_WDATA;
   wire sel_stat = PADDR == `FPRS_OFS_STATUS;
   wire sel_rdata = PADDR == `FPRS_OFS_RDATA;
   wire sel_pairs = PADDR == `FPRS_OFS_PAIRS;
   wire mapped = sel_ctrl | sel_addr | sel_wdata | sel_stat | sel_rdata | sel_pairs;
   wire busy = state_q != S_IDLE;

   // Command launch: only when idle and with a known operation code
   wire [2:0] op_field = PWDATA[`FPRS_CTRL_OP_MSB:`FPRS_CTRL_OP_LSB];
   wire op_ok = op_field != 3'h0 && op_field <= `FPRS_OP_LAST;
   wire go = apb_wr & sel_ctrl & ~busy & op_ok;
   wire fprs_op_e go_op = fprs_op_e'(op_field);

   // Suspend must wait out the gap once the pair count is past the limit
   wire gap_needed = loop_q | (pairs_q > 16'(PAIR_LIMIT));
   wire gap_block = gap_needed & (gap_q != 17'h00000);

   // Read-back mux
   wire [31:0] status_word = {25'h0000000, gap_block, nochange_q, fail_q,
      done_q, busy, loop_q, 1'b0};
   wire [31:0] rd_mux =
      sel_ctrl ? {28'h0000000, loop_q, op_q} :
      sel_addr ? 32'(addr_q) :
      sel_wdata ? {24'h000000, wdata_q} :
      sel_stat ? status_word :
      sel_rdata ? {16'h0000, second_q, rdata_q} :
      sel_pairs ? {16'h0000, pairs_q} : 32'h00000000;

   // APB slave registers
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= apb_acc & ~pready_q;
         pslverr_q <= apb_acc & ~pready_q & ~mapped;
         prdata_q <= (apb_acc & ~pready_q & ~PWRITE) ? rd_mux : 32'h00000000;
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PRDATA = prdata_q;

   // Software-written setup registers; held while an operation runs
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         addr_q <= '0;
         wdata_q <= 8'h00;
         loop_q <= 1'b0;
      end else if (apb_wr & ~busy) begin
         if (sel_addr) addr_q <= PWDATA[AW-1:0];
         if (sel_wdata) wdata_q <= PWDATA[7:0];
         if (sel_ctrl) loop_q <= PWDATA[`FPRS_CTRL_LOOP];
      end
   end

   // Sequence of flash cycles per operation
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_IDLE: if (go) begin
            unique case (go_op)
               OP_PROGRAM: state_d = S_UNLOCK1;
               OP_RESUME: state_d = S_SINGLE;
               OP_SUSPEND: state_d = S_HOLD;
               OP_RESET: state_d = S_RESET;
               OP_READ: state_d = S_READ;
               OP_NONE: state_d = S_IDLE;
            endcase
         end
         S_UNLOCK1: if (cyc_done) state_d = S_UNLOCK2;
         S_UNLOCK2: if (cyc_done) state_d = S_CMD;
         S_CMD: if (cyc_done) state_d = S_DATA;
         S_DATA: if (cyc_done) state_d = S_POLL1;
         S_POLL1: if (cyc_done) state_d = S_POLL2;
         S_POLL2: if (cyc_done) state_d = S_EVAL;
         S_EVAL: begin
            if (!toggling) state_d = S_READ;
            else if (recheck_q) state_d = S_RESET;
            else state_d = S_POLL1;
         end
         S_READ: if (cyc_done) state_d = S_IDLE;
         S_HOLD: if (!gap_block) state_d = S_SINGLE;
         S_SINGLE: if (cyc_done) state_d = S_IDLE;
         S_RESET: if (cyc_done) state_d = S_IDLE;
      endcase
   end

   // Pin cycle request for the state being entered
   wire start_d = is_cyc(state_d) && (state_d != state_q);
   wire cyc_wr = is_wr(state_q);
   wire [AW-1:0] u1_addr = AW'(`FPRS_UNLOCK1_ADDR);
   wire [AW-1:0] u2_addr = AW'(`FPRS_UNLOCK2_ADDR);
   wire [7:0] single_code = (op_q == OP_RESUME) ? `FPRS_RESUME_CODE : `FPRS_SUSPEND_CODE;
   wire [AW-1:0] cyc_addr =
      (state_q == S_UNLOCK1 || state_q == S_CMD || state_q == S_RESET) ? u1_addr :
      (state_q == S_UNLOCK2) ? u2_addr : addr_q;
   wire [7:0] cyc_data =
      (state_q == S_UNLOCK1) ? `FPRS_UNLOCK1_DATA :
      (state_q == S_UNLOCK2) ? `FPRS_UNLOCK2_DATA :
      (state_q == S_CMD) ? `FPRS_PROGRAM_CODE :
      (state_q == S_RESET) ? `FPRS_RESET_CODE :
      (state_q == S_SINGLE) ? single_code : wdata_q;

   // Operation state, start pulse and captured bytes
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state_q <= S_IDLE;
         op_q <= OP_NONE;
         start_q <= 1'b0;
         recheck_q <= 1'b0;
         first_q <= 8'h00;
         second_q <= 8'h00;
      end else begin
         state_q <= state_d;
         start_q <= start_d;
         if (go) op_q <= go_op;
         if (go) recheck_q <= 1'b0;
         if (state_q == S_EVAL && toggling && limit_hit) recheck_q <= 1'b1;
         if (state_q == S_POLL1 && cyc_done) first_q <= cyc_rdata;
         if (state_q == S_POLL2 && cyc_done) second_q <= cyc_rdata;
      end
   end

   // Outcome flags; a new command clears them
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
         nochange_q <= 1'b0;
         rdata_q <= 8'h00;
      end else if (go) begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
         nochange_q <= 1'b0;
      end else begin
         if (state_q == S_EVAL && toggling && recheck_q) fail_q <= 1'b1;
         if (state_q == S_READ && cyc_done) begin
            rdata_q <= cyc_rdata;
            if (op_q == OP_PROGRAM)
               nochange_q <= (cyc_rdata != wdata_q) | ~bits_match;
         end
         if (busy && state_d == S_IDLE) done_q <= 1'b1;
      end
   end

   // Resume count and post-resume gap timer
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         pairs_q <= 16'h0000;
         gap_q <= 17'h00000;
      end else if (state_q == S_SINGLE && cyc_done && op_q == OP_RESUME) begin
         if (pairs_q != 16'hFFFF) pairs_q <= pairs_q + 16'h0001;
         gap_q <= 17'(GAP_CYC);
      end else if (gap_q != 17'h00000) begin
         gap_q <= gap_q - 17'h00001;
      end
   end

   // Strobe generator for the flash pins
   fprs_pin_cycle #(
      .AW(AW)
   ) u_pins (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .start(start_q),
      .wr(cyc_wr),
      .addr(cyc_addr),
      .wdata(cyc_data),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .ce_n(FL_CE_N),
      .we_n(FL_WE_N),
      .oe_n(FL_OE_N),
      .a(FL_ADDR),
      .dq_o(FL_DQ_O),
      .dq_oe(FL_DQ_OE),
      .dq_i(FL_DQ_I)
   );

   // Judges the two status reads against the written byte
   fprs_status_eval u_eval (
      .first(first_q),
      .second(second_q),
      .expect_data(wdata_q),
      .toggling(toggling),
      .limit_hit(limit_hit),
      .bits_match(bits_match)
   );
endmodule

// >>> dv/fprs_ctrl_properties.sv
// Port assertions for the flash controller
`timescale 1ns/1ps
module fprs_ctrl_properties #(
   parameter int AW = 19
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic FL_CE_N,
   input wire logic FL_WE_N,
   input wire logic FL_OE_N,
   input wire logic [AW-1:0] FL_ADDR,
   input wire logic [7:0] FL_DQ_O,
   input wire logic FL_DQ_OE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // Steps of a bus transfer and of a read strobe
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_oe8;
      (!FL_OE_N) [*8];
   endsequence
   property p_rdy_wait;
      s_setup ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY;
   endproperty
   property p_rdy_one;
      PREADY |=> !PREADY;
   endproperty
   property p_idle_bus;
      !PREADY |-> PRDATA == 32'h0 && !PSLVERR;
   endproperty
   property p_we_qual;
      !FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE;
   endproperty
   property p_we_width;
      $fell(FL_WE_N) |=> (!FL_WE_N) [*8] ##1 FL_WE_N;
   endproperty
   property p_we_hold;
      !FL_WE_N |-> $stable(FL_ADDR) && $stable(FL_DQ_O);
   endproperty
   property p_ce_after;
      $rose(FL_WE_N) |-> !FL_CE_N ##1 FL_CE_N;
   endproperty
   property p_rd_len;
      $fell(FL_OE_N) |=> s_oe8 ##1 s_oe8 ##1 !FL_OE_N ##1 FL_OE_N;
   endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("ready timing");
   a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
   a_idle_bus: assert property (p_idle_bus) else $error("bus not idle");
   a_we_qual: assert property (p_we_qual) else $error("bad write strobe");
   a_we_width: assert property (p_we_width) else $error("write width");
   a_we_hold: assert property (p_we_hold) else $error("write data moved");
   a_ce_after: assert property (p_ce_after) else $error("select order");
   a_rd_len: assert property (p_rd_len) else $error("read width");
endmodule
bind fprs_ctrl fprs_ctrl_properties #(.AW(AW)) fprs_ctrl_properties_inst (.SYS_CLK, .RST_N,
   .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR, .FL_CE_N, .FL_WE_N, .FL_OE_N, .FL_ADDR,
   .FL_DQ_O, .FL_DQ_OE);

// >>> dv/fprs_flash_model.sv
// Behavioural parallel flash answering the controller's pin cycles
`timescale 1ns/1ps
`include "fprs_consts.svh"
module fprs_flash_model #(
   parameter int PAIR_LIMIT = 2,
   parameter real GAP_NS = 170.0,
   parameter logic [2:0] PROT_SEC = 3'h6,
   parameter logic [2:0] ERASE_SEC = 3'h4
) (
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [18:0] a,
   input wire logic [7:0] dq_o,
   input wire logic dq_oe,
   output logic [7:0] dq_i,
   input wire logic [7:0] busy_reads,
   input wire logic lock,
   input wire logic gap_all
);
   logic [7:0] mem [int];
   logic [7:0] rd = 8'h00, last = 8'h00;
   logic [18:0] al = 19'h0;
   logic busy = 1'h0, susp = 1'h0, tog = 1'h0, tle = 1'h0, lock_on = 1'h0, tog2 = 1'h0;
   int stg = 0, left = 0, nres = 0, nrst = 0, bad = 0;
   realtime tres = 0;
   // Released bus shows the inverse of the last value
   assign dq_i = (!ce_n && !oe_n) ? rd : ~rd;
   // Address taken on the falling write strobe
   always @(negedge we_n) begin
      if (!ce_n) al = a;
   end
   // Commands decoded on the rising write strobe
   always @(posedge we_n) begin
      if (!ce_n) begin
         if (!dq_oe) bad++;
         if (dq_o == `FPRS_RESET_CODE) begin
            busy = 1'h0;
            tle = 1'h0;
            stg = 0;
            nrst++;
         end else if (busy) begin
            bad++;
         end else if (stg == 3) begin
            // A protected sector keeps its byte but still shows busy status
            if (al[18:16] != PROT_SEC) begin
               mem[al] = (mem.exists(al) ? mem[al] : 8'hFF) & dq_o;
            end
            last = dq_o;
            left = busy_reads;
            lock_on = lock;
            busy = 1'h1;
            stg = 0;
         end else if (stg == 2 && al == `FPRS_UNLOCK1_ADDR && dq_o == `FPRS_PROGRAM_CODE) begin
            stg = 3;
         end else if (stg == 1 && al == `FPRS_UNLOCK2_ADDR && dq_o == `FPRS_UNLOCK2_DATA) begin
            stg = 2;
         end else if (al == `FPRS_UNLOCK1_ADDR && dq_o == `FPRS_UNLOCK1_DATA) begin
            stg = 1;
         end else if (dq_o == `FPRS_SUSPEND_CODE) begin
            if ((nres > PAIR_LIMIT || gap_all) && $realtime - tres < GAP_NS) bad++;
            susp = 1'h1;
            stg = 0;
         end else if (dq_o == `FPRS_RESUME_CODE) begin
            susp = 1'h0;
            nres++;
            tres = $realtime;
            stg = 0;
         end else begin
            bad++;
            stg = 0;
         end
      end
   end
   // Status or array data launched at the falling read strobe
   always @(negedge oe_n) begin
      if (!ce_n) begin
         if (busy && left == 0 && !lock_on) busy = 1'h0;
         if (busy) begin
            tog = ~tog;
            rd = {~last[7], tog, tle, 5'h00};
            if (left > 0) begin
               left--;
            end else begin
               tle = 1'h1;
            end
         end else if (susp && a[18:16] == ERASE_SEC) begin
            // Suspended erase sector: bit 6 steady, bit 2 toggles
            tog2 = ~tog2;
            rd = {1'h1, tog, 3'h0, tog2, 2'h0};
         end else begin
            rd = mem.exists(a) ? mem[a] : 8'hFF;
         end
      end
   end
endmodule

// >>> dv/flash_program_resume_status_bench.sv
// Self-checking bench for the flash program, resume and status controller
`timescale 1ns/1ps
`include "fprs_consts.svh"
module flash_program_resume_status_bench;
   logic SYS_CLK = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic [7:0] PADDR = 8'h00, FL_DQ_O, FL_DQ_I, busy_reads = 8'h00, dat, r1;
   logic [31:0] PWDATA = 32'h0, PRDATA, rdv;
   logic PREADY, PSLVERR, FL_CE_N, FL_WE_N, FL_OE_N, FL_DQ_OE, errv;
   logic lock = 1'h0, gap_all = 1'h0;
   logic [18:0] FL_ADDR, adr;
   int num_errors = 0, n_tests = 0, seed = 35;
   fprs_ctrl #(.GAP_CYC(50), .PAIR_LIMIT(2)) fprs_ctrl_inst (.SYS_CLK, .RST_N, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FL_CE_N, .FL_WE_N,
      .FL_OE_N, .FL_ADDR, .FL_DQ_O, .FL_DQ_OE, .FL_DQ_I);
   fprs_flash_model #(.PAIR_LIMIT(2), .GAP_NS(170.0)) fprs_flash_model_inst (.ce_n(FL_CE_N),
      .we_n(FL_WE_N), .oe_n(FL_OE_N), .a(FL_ADDR), .dq_o(FL_DQ_O), .dq_oe(FL_DQ_OE),
      .dq_i(FL_DQ_I), .busy_reads, .lock, .gap_all);
   // 200 MHz clock
   initial begin
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   // Verdict and end of run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge SYS_CLK);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= wd;
      @(posedge SYS_CLK);
      PENABLE <= 1'h1;
      // Ready, read data and error are taken at the edge that completes it
      do begin
         @(posedge SYS_CLK);
         k++;
      end while (PREADY !== 1'h1 && k < 40);
      rdv = PRDATA;
      errv = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      if (k >= 40) begin
         chk(32'h0, 32'h1);
         tally_and_finish;
      end
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      do begin
         apb(1'h0, `FPRS_OFS_STATUS, 32'h0);
         k++;
      end while (rdv[2] !== 1'h0 && k < 500);
      if (k >= 500) begin
         chk(32'h0, 32'h1);
         tally_and_finish;
      end
   endtask
   task automatic prog(input logic [18:0] a, input logic [7:0] d, input logic [7:0] br);
      busy_reads <= br;
      apb(1'h1, `FPRS_OFS_ADDR, {13'h0, a});
      apb(1'h1, `FPRS_OFS_WDATA, {24'h0, d});
      apb(1'h1, `FPRS_OFS_CTRL, 32'h1);
   endtask
   // Expected status after programming over an old byte
   function automatic logic [31:0] stat_exp(input logic [7:0] old, input logic [7:0] d);
      return ((old & d) == d) ? 32'h8 : 32'h28;
   endfunction
   task automatic ctl(input logic [31:0] v);
      apb(1'h1, `FPRS_OFS_CTRL, v);
      wait_idle;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge SYS_CLK);
      RST_N <= 1'h1;
      apb(1'h0, `FPRS_OFS_STATUS, 32'h0);
      chk(rdv, 32'h0);
      apb(1'h0, 8'h20, 32'h0);
      chk({rdv[30:0], errv}, 32'h1);
      apb(1'h1, 8'h18, 32'h5);
      chk({31'h0, errv}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         adr = {i[2:0], 16'($random(seed))};
         dat = 8'($random(seed));
         prog(adr, dat, (i == 0) ? 8'h00 : (i == 5) ? 8'h07 : 8'($random(seed)) & 8'h05);
         apb(1'h1, `FPRS_OFS_ADDR, 32'h0);
         wait_idle;
         chk(rdv & 32'h3C, stat_exp(8'hFF, dat));
         chk({24'h0, fprs_flash_model_inst.mem[adr]}, {24'h0, dat});
         apb(1'h0, `FPRS_OFS_RDATA, 32'h0);
         chk(rdv, {16'h0, dat, dat});
         apb(1'h0, `FPRS_OFS_ADDR, 32'h0);
         chk(rdv, {13'h0, adr});
      end
      prog(19'h7FFFF, 8'h00, 8'h01);
      wait_idle;
      prog(19'h7FFFF, 8'hC0, 8'h01);
      wait_idle;
      chk(rdv & 32'h3C, stat_exp(8'h00, 8'hC0));
      lock <= 1'h1;
      prog(19'h70000, 8'h5A, 8'h02);
      wait_idle;
      lock <= 1'h0;
      chk(rdv & 32'h34, 32'h10);
      chk({31'h0, fprs_flash_model_inst.busy}, 32'h0);
      prog(19'h70001, 8'h3C, 8'h01);
      wait_idle;
      chk(rdv & 32'h3C, stat_exp(8'hFF, 8'h3C));
      // Program into the protected sector leaves the byte as it was
      prog(19'h60000, 8'h12, 8'h02);
      wait_idle;
      chk(rdv & 32'h3C, 32'h28);
      chk(32'(fprs_flash_model_inst.mem.exists(19'h60000)), 32'h0);
      ctl(32'h4);
      chk(32'(fprs_flash_model_inst.nrst), 32'h2);
      apb(1'h1, `FPRS_OFS_ADDR, {13'h0, adr});
      ctl(32'h5);
      apb(1'h0, `FPRS_OFS_RDATA, 32'h0);
      chk({24'h0, rdv[7:0]}, {24'h0, dat});
      gap_all <= 1'h1;
      ctl(32'hA);
      ctl(32'hB);
      gap_all <= 1'h0;
      for (int i = 0; i < 3; i++) begin
         ctl(32'h2);
         ctl(32'h3);
      end
      chk({31'h0, fprs_flash_model_inst.susp}, 32'h1);
      ctl(32'h6);
      apb(1'h0, `FPRS_OFS_CTRL, 32'h0);
      chk(rdv, 32'h3);
      // Two reads in the suspended erase sector: bit 2 moves, bit 6 stays
      apb(1'h1, `FPRS_OFS_ADDR, 32'h40000);
      ctl(32'h5);
      apb(1'h0, `FPRS_OFS_RDATA, 32'h0);
      r1 = rdv[7:0];
      ctl(32'h5);
      apb(1'h0, `FPRS_OFS_RDATA, 32'h0);
      chk({24'h0, (r1 ^ rdv[7:0]) & 8'h44}, 32'h4);
      apb(1'h0, `FPRS_OFS_PAIRS, 32'h0);
      chk(rdv, 32'h4);
      chk(32'(fprs_flash_model_inst.bad), 32'h0);
      tally_and_finish;
   end
endmodule
